// *** rtl/fhr_top.sv ***
/*
 Fault history recorder: keeps the newest fault records as register
 pairs read by the serial master, and drives the fault indicator.
 Assumes fault events, reads and writes come from logic on SYS_CLK_I.
*/
// Contract
// - Keep the ten newest fault records
// - Two registers per record, written on detection
// - Identifier packs origin, category, sub-code
// - Second register holds the tested value
// - Processor faults: origin 1, categories 0-5
// - Reset sub-code flags one reset cause
// - Temperature faults: origins 2, 3, categories 0-3
// - Sensor hardware faults: origin 4, category 0
// - Internal bus faults: origin 5, devices 0-3
// - Serial protocol faults: origin 6, categories 0-3
// - Clear command only turns indicator off
`timescale 1ns/10ps
`include "fhr_defs.svh"

module fhr_top
    import fhr_pkg::*;
(
    input  wire logic        SYS_CLK_I,
    input  wire logic        RST_B_I,
    input  wire logic        EV_VALID_I,
    input  wire logic [3:0]  EV_ORIGIN_I,
    input  wire logic [3:0]  EV_CAT_I,
    input  wire logic [7:0]  EV_SUB_I,
    input  wire logic [15:0] EV_DATA_I,
    output logic             EV_REJECT_O,
    input  wire logic        RD_REQ_I,
    input  wire logic [15:0] RD_ADDR_I,
    output logic             RD_BUSY_O,
    output logic             RD_VALID_O,
    output logic             RD_ERR_O,
    output logic [15:0]      RD_DATA_O,
    input  wire logic        WR_REQ_I,
    input  wire logic [15:0] WR_ADDR_I,
    input  wire logic [15:0] WR_DATA_I,
    output logic             FAULT_LED_O,
    output logic [3:0]       REC_COUNT_O
);
    // ==========================================================
    // Helpers
    function automatic logic code_ok(input logic [3:0] o,
                                     input logic [3:0] c,
                                     input logic [7:0] s);
        logic ok;
        ok = 1'b0;
        case (o)
            FHR_ORG_CPU:
                ok = (c <= 4'h5) && ((c != 4'h5) ||
                     ((s != 8'h00) && ((s & (s - 8'h01)) == 8'h00)
                      && !s[7]));
            FHR_ORG_STACK, FHR_ORG_AMB:
                ok = (c <= 4'h3);
            FHR_ORG_O2:
                case (c)
                    4'h0:    ok = (s >= 8'h01) && (s <= 8'h0B)
                                  && (s != 8'h07);
                    4'h1:    ok = (s <= 8'h08);
                    4'h2:    ok = (s <= 8'h01);
                    default: ok = 1'b0;
                endcase
            FHR_ORG_IBUS:
                ok = (c <= 4'h2) && (s <= 8'h03);
            FHR_ORG_MODBUS:
                ok = (c <= 4'h3);
            default:
                ok = 1'b0;
        endcase
        return ok;
    endfunction

    // Newest record is index 0; wraps modulo record count
    function automatic logic [3:0] phys(input logic [3:0] wp,
                                        input logic [3:0] rec);
        logic [4:0] t;
        t = 5'(wp) + 5'(`FHR_NUM_REC - 1) - 5'(rec);
        if (t >= 5'(`FHR_NUM_REC))
        begin
            t = t - 5'(`FHR_NUM_REC);
        end
        return t[3:0];
    endfunction

    // ==========================================================
    // Recording
    fhr_mem_if mif ();

    logic       ev_ok;
    logic [3:0] wp_q;
    logic [3:0] wp_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic       rej_q;
    logic       rej_d;
    logic       led_q;
    logic       led_d;
    logic       clr_cmd;

    // Legal code check
    // Applies to every origin; unknown codes are not stored
    assign ev_ok = EV_VALID_I &&
                   code_ok(EV_ORIGIN_I, EV_CAT_I, EV_SUB_I);
    assign clr_cmd = WR_REQ_I && (WR_ADDR_I == `FHR_STATUS_IDX) &&
                     (WR_DATA_I == `FHR_LED_CLR_CMD);

    assign mif.wr_en   = ev_ok;
    assign mif.wr_addr = wp_q;
    assign mif.wr_data[31:16] = {EV_ORIGIN_I, EV_CAT_I, EV_SUB_I};
    assign mif.wr_data[15:0]  = EV_DATA_I;

    always_comb
    begin
        wp_d  = wp_q;
        cnt_d = cnt_q;
        rej_d = EV_VALID_I && !ev_ok;
        led_d = led_q;
        if (ev_ok)
        begin
            wp_d = (wp_q == 4'(`FHR_NUM_REC - 1)) ? 4'h0 : wp_q + 4'h1;
            if (cnt_q != 4'(`FHR_NUM_REC))
            begin
                cnt_d = cnt_q + 4'h1;
            end
        end
        // Only the indicator; a new fault wins
        if (clr_cmd)
        begin
            led_d = 1'b0;
        end
        if (ev_ok)
        begin
            led_d = 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            wp_q  <= 4'h0;
            cnt_q <= 4'h0;
            rej_q <= 1'b0;
            led_q <= 1'b0;
        end
        else
        begin
            wp_q  <= wp_d;
            cnt_q <= cnt_d;
            rej_q <= rej_d;
            led_q <= led_d;
        end
    end

    // ==========================================================
    // Register reads
    fhr_state_e  st_q;
    fhr_state_e  st_d;
    logic [15:0] idx;
    logic        in_rng;
    logic        half_q;
    logic        half_d;
    logic        occ_q;
    logic        occ_d;
    logic        err_q;
    logic        err_d;
    logic        vld_q;
    logic        vld_d;
    logic [15:0] dat_q;
    logic [15:0] dat_d;

    assign idx    = RD_ADDR_I - `FHR_HIST_BASE;
    assign in_rng = (RD_ADDR_I >= `FHR_HIST_BASE) &&
                    (idx < `FHR_HIST_REGS);
    assign mif.rd_en   = RD_REQ_I && (st_q == FHR_ST_IDLE) && in_rng;
    assign mif.rd_addr = phys(wp_q, idx[4:1]);

    always_comb
    begin
        st_d   = st_q;
        half_d = half_q;
        occ_d  = occ_q;
        err_d  = err_q;
        vld_d  = 1'b0;
        dat_d  = dat_q;
        case (st_q)
            FHR_ST_IDLE:
                if (RD_REQ_I)
                begin
                    st_d   = FHR_ST_WAIT;
                    half_d = idx[0];
                    occ_d  = in_rng && ({1'b0, idx[4:1]} < {1'b0, cnt_q});
                    err_d  = !in_rng;
                end
            FHR_ST_WAIT:
            begin
                st_d  = FHR_ST_IDLE;
                vld_d = 1'b1;
                dat_d = !occ_q ? `FHR_RESET_WORD :
                        half_q ? mif.rd_data[15:0] : mif.rd_data[31:16];
            end
            default:
                st_d = FHR_ST_IDLE;
        endcase
    end

    always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            st_q   <= FHR_ST_IDLE;
            half_q <= 1'b0;
            occ_q  <= 1'b0;
            err_q  <= 1'b0;
            vld_q  <= 1'b0;
            dat_q  <= `FHR_RESET_WORD;
        end
        else
        begin
            st_q   <= st_d;
            half_q <= half_d;
            occ_q  <= occ_d;
            err_q  <= err_d;
            vld_q  <= vld_d;
            dat_q  <= dat_d;
        end
    end

    fhr_mem u_mem
    (
        .clk_i   (SYS_CLK_I),
        .rst_b_i (RST_B_I),
        .port    (mif.mem)
    );

    assign EV_REJECT_O = rej_q;
    assign RD_BUSY_O   = (st_q != FHR_ST_IDLE);
    assign RD_VALID_O  = vld_q;
    assign RD_ERR_O    = vld_q && err_q;
    assign RD_DATA_O   = dat_q;
    assign FAULT_LED_O = led_q;
    assign REC_COUNT_O = cnt_q;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!RST_B_I);

    a_rec_limit: assert property (cnt_q <= 4'(`FHR_NUM_REC))
        else $error("record count above ten");
    a_rec_write: assert property (ev_ok |=> cnt_q != 4'h0 && led_q)
        else $error("fault not recorded");
    a_id_pack: assert property (ev_ok |=>
        u_mem.mem_q[$past(wp_q)][31:28] == $past(EV_ORIGIN_I) &&
        u_mem.mem_q[$past(wp_q)][23:16] == $past(EV_SUB_I))
        else $error("identifier misplaced");
    a_data_keep: assert property (ev_ok |=>
        u_mem.mem_q[$past(wp_q)][15:0] == $past(EV_DATA_I) &&
        u_mem.mem_q[$past(wp_q)][27:24] == $past(EV_CAT_I))
        else $error("data word wrong");
    a_cpu_cat: assert property (mif.wr_en && EV_ORIGIN_I == 4'h1
        |-> EV_CAT_I <= 4'h5)
        else $error("bad processor category");
    a_reset_cause: assert property (mif.wr_en && EV_ORIGIN_I == 4'h1
        && EV_CAT_I == 4'h5 |-> $onehot(EV_SUB_I) && !EV_SUB_I[7])
        else $error("bad reset cause");
    a_temp_cat: assert property (mif.wr_en && (EV_ORIGIN_I == 4'h2
        || EV_ORIGIN_I == 4'h3) |-> EV_CAT_I <= 4'h3)
        else $error("bad temperature category");
    a_o2_hw: assert property (mif.wr_en && EV_ORIGIN_I == 4'h4
        && EV_CAT_I == 4'h0 |-> EV_SUB_I inside {[8'h01:8'h06],
                                                 [8'h08:8'h0B]})
        else $error("bad sensor hardware code");
    a_o2_ops: assert property (mif.wr_en && EV_ORIGIN_I == 4'h4
        && EV_CAT_I != 4'h0 |-> EV_CAT_I <= 4'h2 && EV_SUB_I <= 8'h08)
        else $error("bad sensor comms code");
    a_ibus_code: assert property (mif.wr_en && EV_ORIGIN_I == 4'h5
        |-> EV_CAT_I <= 4'h2 && EV_SUB_I <= 8'h03)
        else $error("bad internal bus code");
    a_mb_code: assert property (EV_VALID_I && EV_ORIGIN_I == 4'h6
        && EV_CAT_I <= 4'h3 |-> mif.wr_en)
        else $error("protocol fault dropped");
    a_wrap_oldest: assert property (ev_ok && cnt_q == 4'hA
        |=> cnt_q == 4'hA && wp_q != $past(wp_q))
        else $error("oldest not overwritten");
    a_led_clear: assert property (clr_cmd && !ev_ok
        |=> !FAULT_LED_O && cnt_q == $past(cnt_q) && wp_q == $past(wp_q))
        else $error("clear touched history");
    a_read_lat: assert property (RD_REQ_I && !RD_BUSY_O
        |=> RD_BUSY_O ##1 RD_VALID_O && !RD_BUSY_O)
        else $error("read answer late");

    c_wrap: cover property (ev_ok && cnt_q == 4'hA);
    c_clear: cover property (clr_cmd && led_q);
    c_read: cover property (RD_VALID_O && !RD_ERR_O && RD_DATA_O != 16'h0);
    c_reject: cover property (EV_REJECT_O);
endmodule // fhr_top

// *** rtl/fhr_defs.svh ***
/*
 Fault history recorder constants: record count, field positions,
 register indices and command values.
 Assumes inclusion by the recorder RTL sources, the memory interface included.
*/
`ifndef FHR_DEFS_SVH
`define FHR_DEFS_SVH

// ==========================================================
// Record store
`define FHR_NUM_REC      10
`define FHR_REC_W        32
`define FHR_PTR_W        4
`define FHR_CNT_W        4

// ==========================================================
// Identifier field positions
`define FHR_ORG_MSB      15
`define FHR_ORG_LSB      12
`define FHR_CAT_MSB      11
`define FHR_CAT_LSB      8
`define FHR_SUB_MSB      7
`define FHR_SUB_LSB      0

// ==========================================================
// Register indices and commands
`define FHR_HIST_BASE    16'h0020
`define FHR_HIST_REGS    16'h0014
`define FHR_STATUS_IDX   16'h0000
`define FHR_LED_CLR_CMD  16'hA5A5
`define FHR_RESET_WORD   16'h0000

`endif

// *** rtl/fhr_pkg.sv ***
/*
 Fault history recorder types: fault origins and read states.
 Assumes the constants header is compiled alongside.
*/
package fhr_pkg;

    // ==========================================================
    // Fault origins
    typedef enum logic [3:0]
    {
        FHR_ORG_CPU    = 4'h1,
        FHR_ORG_STACK  = 4'h2,
        FHR_ORG_AMB    = 4'h3,
        FHR_ORG_O2     = 4'h4,
        FHR_ORG_IBUS   = 4'h5,
        FHR_ORG_MODBUS = 4'h6
    } fhr_origin_e;

    // ==========================================================
    // Read sequencer states
    typedef enum logic [1:0]
    {
        FHR_ST_IDLE = 2'b01,
        FHR_ST_WAIT = 2'b10
    } fhr_state_e;

endpackage

// *** rtl/fhr_mem_if.sv ***
/*
 Carrier between the recorder and its record memory.
 Assumes both ends share one clock.
*/
`timescale 1ns/10ps
`include "fhr_defs.svh"

interface fhr_mem_if;
    logic                     wr_en;
    logic [`FHR_PTR_W-1:0]    wr_addr;
    logic [`FHR_REC_W-1:0]    wr_data;
    logic                     rd_en;
    logic [`FHR_PTR_W-1:0]    rd_addr;
    logic [`FHR_REC_W-1:0]    rd_data;

    modport ctrl
    (
        output wr_en, wr_addr, wr_data, rd_en, rd_addr,
        input  rd_data
    );
    modport mem
    (
        input  wr_en, wr_addr, wr_data, rd_en, rd_addr,
        output rd_data
    );
endinterface

// *** rtl/fhr_mem.sv ***
/*
 Record memory: one write port, one read port, registered read data.
 Assumes unoccupied words are masked by the caller.
*/
`timescale 1ns/10ps
`include "fhr_defs.svh"

module fhr_mem
    import fhr_pkg::*;
#(
    parameter int DEPTH = `FHR_NUM_REC
)
(
    input  wire logic   clk_i,
    input  wire logic   rst_b_i,
    fhr_mem_if.mem      port
);
    // ==========================================================
    // Storage
    logic [`FHR_REC_W-1:0] mem_q [DEPTH];
    logic [`FHR_REC_W-1:0] rd_q;
    logic [`FHR_REC_W-1:0] rd_d;

    always_comb
    begin
        rd_d = rd_q;
        if (port.rd_en)
        begin
            rd_d = mem_q[port.rd_addr];
        end
    end

    // No reset on the array; reads of empty slots are masked upstream
    always_ff @(posedge clk_i)
    begin
        if (port.wr_en)
        begin
            mem_q[port.wr_addr] <= port.wr_data;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rd_q <= '0;
        end
        else
        begin
            rd_q <= rd_d;
        end
    end

    assign port.rd_data = rd_q;
endmodule // fhr_mem

// *** tb/fhr_master.sv ***
/*
 Serial master stand-in: single register reads and writes.
 Assumes every task call starts just after a rising clock edge.
*/
`timescale 1ns/10ps

module fhr_master
(
    input  wire logic        clk_i,
    input  wire logic        rd_valid_i,
    input  wire logic        rd_err_i,
    input  wire logic [15:0] rd_data_i,
    output logic             rd_req_o,
    output logic [15:0]      rd_addr_o,
    output logic             wr_req_o,
    output logic [15:0]      wr_addr_o,
    output logic [15:0]      wr_data_o
);
    // ==========================================================
    // Idle levels
    initial
    begin
        rd_req_o  = 1'b0;
        rd_addr_o = 16'h5A5A;
        wr_req_o  = 1'b0;
        wr_addr_o = 16'hA5A5;
        wr_data_o = 16'h5A5A;
    end

    // ==========================================================
    // Read: latency counted in cycles, the taken edge counted as the first
    task automatic rd(input logic [15:0] a, output logic [15:0] d,
                      output logic e, output int lat);
        rd_req_o  = 1'b1;
        rd_addr_o = a;
        @(posedge clk_i);
        #1;
        rd_req_o  = 1'b0;
        // Released lines show a changed value, not the old one
        rd_addr_o = ~a;
        lat = 1;
        while (rd_valid_i !== 1'b1 && lat < 6)
        begin
            @(posedge clk_i);
            #1;
            lat++;
        end
        d = rd_data_i;
        e = rd_err_i;
    endtask

    // ==========================================================
    // single register write
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        wr_req_o  = 1'b1;
        wr_addr_o = a;
        wr_data_o = d;
        @(posedge clk_i);
        #1;
        wr_req_o  = 1'b0;
        wr_addr_o = ~a;
        wr_data_o = ~d;
        // Let an edge pass so a following write never re-raises at once
        @(posedge clk_i);
        #1;
    endtask
endmodule // fhr_master

// *** tb/test_fault_history_recorder.sv ***
/*
 Self-checking bench for the fault history recorder with a queue model.
 Assumes the design and the master stand-in are compiled first.
*/
`timescale 1ns/10ps

module test_fault_history_recorder;
    logic        sys_clk, rst_b, ev_valid, ev_reject, rd_req;
    logic        rd_busy, rd_valid, rd_err, wr_req, led, led_m;
    logic [3:0]  ev_origin, ev_cat, rec_count;
    logic [7:0]  ev_sub;
    logic [15:0] ev_data, rd_addr, rd_data, wr_addr, wr_data;
    logic [31:0] hist_q[$];
    logic [31:0] r;
    int          fail_count = 0;
    int          compares = 0;
    int          cycles = 0;
    int          seed = 32'hD56445C7;

    fhr_top fhr_top_inst (.SYS_CLK_I(sys_clk), .RST_B_I(rst_b),
        .EV_VALID_I(ev_valid), .EV_ORIGIN_I(ev_origin), .EV_CAT_I(ev_cat),
        .EV_SUB_I(ev_sub), .EV_DATA_I(ev_data), .EV_REJECT_O(ev_reject),
        .RD_REQ_I(rd_req), .RD_ADDR_I(rd_addr), .RD_BUSY_O(rd_busy),
        .RD_VALID_O(rd_valid), .RD_ERR_O(rd_err), .RD_DATA_O(rd_data),
        .WR_REQ_I(wr_req), .WR_ADDR_I(wr_addr), .WR_DATA_I(wr_data),
        .FAULT_LED_O(led), .REC_COUNT_O(rec_count));

    fhr_master fhr_master_inst (.clk_i(sys_clk), .rd_valid_i(rd_valid),
        .rd_err_i(rd_err), .rd_data_i(rd_data), .rd_req_o(rd_req),
        .rd_addr_o(rd_addr), .wr_req_o(wr_req), .wr_addr_o(wr_addr),
        .wr_data_o(wr_data));

    // ==========================================================
    // Clock and hang guard
    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            fail_count++;
            end_of_test();
        end
    end

    // ==========================================================
    // Checking helpers
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic legal(logic [3:0] o, c, logic [7:0] s);
        case (o)
            4'h1: return c <= 5 && (c != 5 ||
                  (s != 0 && s < 8'h80 && (s & (s - 1)) == 0));
            4'h2, 4'h3, 4'h6: return c <= 3;
            4'h4: return (c == 0 && s >= 1 && s <= 8'h0B && s != 7) ||
                  (c == 1 && s <= 8) || (c == 2 && s <= 1);
            4'h5: return c <= 2 && s <= 3;
            default: return 1'b0;
        endcase
    endfunction

    // Holds strobe high, so back to back calls make a burst
    task automatic ev(input logic [3:0] o, c, input logic [7:0] s,
                      input logic [15:0] d);
        logic ok;
        ok        = legal(o, c, s);
        ev_valid  = 1'b1;
        ev_origin = o;
        ev_cat    = c;
        ev_sub    = s;
        ev_data   = d;
        @(posedge sys_clk);
        #1;
        if (ok)
        begin
            hist_q.push_front({o, c, s, d});
            if (hist_q.size() > 10)
                hist_q.pop_back();
            led_m = 1'b1;
        end
        cmp({15'h0, ev_reject}, {15'h0, ~ok});
        cmp({12'h0, rec_count}, 16'(hist_q.size()));
        cmp({15'h0, led}, {15'h0, led_m});
    endtask

    task automatic idle();
        ev_valid = 1'b0;
        ev_sub   = ~ev_sub;
        ev_data  = ~ev_data;
    endtask

    task automatic rd_chk(input logic [15:0] a);
        logic [15:0] d, exp;
        logic        e, ee, b;
        int          lat, n;
        fork
            fhr_master_inst.rd(a, d, e, lat);
            begin
                @(posedge sys_clk);
                #1;
                b = rd_busy;
            end
        join
        ee  = a < 16'h0020 || a > 16'h0033;
        n   = (int'(a) - 32) / 2;
        exp = 16'h0000;
        if (!ee && n < hist_q.size())
            exp = a[0] ? hist_q[n][15:0] : hist_q[n][31:16];
        cmp(d, exp);
        cmp({15'h0, e}, {15'h0, ee});
        cmp(16'(lat), 16'h0002);
        cmp({15'h0, b}, 16'h0001);
    endtask

    task automatic chk_all();
        for (int a = 16'h001F; a <= 16'h0034; a++)
            rd_chk(16'(a));
    endtask

    task automatic done(input string name);
        $display("test %s done: %0d compares, %0d fails", name, compares,
                 fail_count);
    endtask

    task automatic end_of_test();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial
    begin
        {ev_valid, ev_origin, ev_cat, ev_sub, ev_data} = '0;
        led_m = 1'b0;
        rst_b = 1'b0;
        repeat (5) @(posedge sys_clk);
        #1;
        rst_b = 1'b1;
        cmp({12'h0, rec_count}, 16'h0000);
        cmp({15'h0, led}, 16'h0000);
        chk_all();
        done("reset");
        for (int o = 0; o < 8; o++)
            for (int c = 0; c < 7; c++)
            begin
                ev(4'(o), 4'(c), (o == 1 && c == 5) ? 8'h08 : 8'(c),
                   16'($random(seed)));
                idle();
                chk_all();
            end
        done("codes");
        for (int i = 0; i < 9; i++)
        begin
            ev(4'h1, 4'h5, i < 8 ? 8'h01 << i : 8'h03,
               16'($random(seed)));
            idle();
            rd_chk(16'h0020);
        end
        for (int s = 0; s < 16; s++)
        begin
            ev(4'h4, 4'h0, 8'(s), 16'($random(seed)));
            idle();
            rd_chk(16'h0020);
        end
        done("subcodes");
        repeat (30)
        begin
            r = $random(seed);
            ev({1'b0, r[2:0]}, {2'b00, r[5:4]}, {4'h0, r[11:8]},
               r[31:16]);
        end
        idle();
        chk_all();
        done("burst");
        fhr_master_inst.wr(16'h0000, 16'h1234);
        cmp({15'h0, led}, {15'h0, led_m});
        fhr_master_inst.wr(16'h0001, 16'hA5A5);
        cmp({15'h0, led}, {15'h0, led_m});
        fhr_master_inst.wr(16'h0000, 16'hA5A5);
        led_m = 1'b0;
        cmp({15'h0, led}, 16'h0000);
        cmp({12'h0, rec_count}, 16'(hist_q.size()));
        chk_all();
        fork
            begin
                ev(4'h6, 4'h2, 8'h11, 16'hBEEF);
                idle();
            end
            fhr_master_inst.wr(16'h0000, 16'hA5A5);
        join
        chk_all();
        done("clear");
        end_of_test();
    end
endmodule // test_fault_history_recorder
